//--- src/fcr_consts.svh
`ifndef FCR_CONSTS_SVH
`define FCR_CONSTS_SVH
`define FCR_ADDR_W 32
`define FCR_CODE_HIGH 24'hFFFFFF
`define FCR_BIT_SELF 7
`define FCR_OTHER_ONES 7'h60
`define FCR_SELF_MASK 7'h7C
`define FCR_OTHER_MASK 7'h1C
`define FCR_BIT_ALIGN 4
`define FCR_BIT_RUNTIME 3
`define FCR_BIT_BUSCONF 2
`define FCR_MASK_W 7
`define FCR_SYNC_DEPTH 3
`define FCR_RDY_N_IDLE 1'h1
`define FCR_RDY_RST 1'h0
`define FCR_ADDR_RST 32'h00000000
`define FCR_FAIL_N_RST 1'h1
`define FCR_HALT_RST 1'h0
`define FCR_DONE_RST 1'h0
`define FCR_WNR_READ 1'h0
`endif

//--- src/fcr_pkg.sv
package fcr_pkg;
   typedef enum logic [3:0] {
      FCR_RUN = 4'h1,
      FCR_ADDR = 4'h2,
      FCR_WAIT = 4'h4,
      FCR_HALT = 4'h8
   } fcr_state_t;
endpackage : fcr_pkg

//--- src/fcr_reporter.sv
`timescale 1ns/1ps
`include "fcr_consts.svh"
module fcr_reporter (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic [4:0] self_check_fail_in,
   input wire logic image_misaligned_in,
   input wire logic runtime_error_in,
   input wire logic bus_confidence_fail_in,
   input wire logic ready_n_in,
   output logic fail_n_out,
   output logic halt_out,
   output logic [`FCR_ADDR_W-1:0] addr_out,
   output logic address_strobe_n_out,
   output logic write_not_read_out,
   output logic blast_n_out,
   output logic done_out
);
   // state machine group
   fcr_pkg::fcr_state_t state_q;
   fcr_pkg::fcr_state_t state_d;

   // fail code and status group
   logic [`FCR_ADDR_W-1:0] addr_q;
   logic [`FCR_ADDR_W-1:0] addr_d;
   logic fail_n_q;
   logic fail_n_d;
   logic halt_q;
   logic halt_d;
   logic done_q;
   logic done_d;

   // ready pin synchroniser group
   logic [`FCR_SYNC_DEPTH-1:0] rdy_sync_q;
   logic [`FCR_SYNC_DEPTH-1:0] rdy_sync_d;
   logic rdy_q;
   logic rdy_d;

   // cause decode
   logic self_err;
   logic other_err;
   logic any_err;
   logic [`FCR_MASK_W-1:0] mask_self;
   logic [`FCR_MASK_W-1:0] mask_other;
   logic [`FCR_ADDR_W-1:0] code_self;
   logic [`FCR_ADDR_W-1:0] code_other;

   // normal operation, no failure captured yet
   function automatic logic in_run(input fcr_pkg::fcr_state_t st);
      logic hit;
      hit = (st == fcr_pkg::FCR_RUN);
      return hit;
   endfunction : in_run

   // first clock of the fail code access
   function automatic logic in_addr_cycle(input fcr_pkg::fcr_state_t st);
      logic hit;
      hit = (st == fcr_pkg::FCR_ADDR);
      return hit;
   endfunction : in_addr_cycle

   // address or wait clock of the access
   function automatic logic in_access(input fcr_pkg::fcr_state_t st);
      logic hit;
      hit = (st == fcr_pkg::FCR_ADDR) || (st == fcr_pkg::FCR_WAIT);
      return hit;
   endfunction : in_access

   // access ends when filtered ready is seen in the wait clock
   function automatic logic access_done(input fcr_pkg::fcr_state_t st, input logic rdy);
      logic hit;
      hit = (st == fcr_pkg::FCR_WAIT) && rdy;
      return hit;
   endfunction : access_done

   // fail code word: all-ones top, format flag, cause mask
   function automatic logic [`FCR_ADDR_W-1:0] make_code(
      input logic self_fmt,
      input logic [`FCR_MASK_W-1:0] mask
   );
      logic [`FCR_ADDR_W-1:0] code;
      code = {`FCR_CODE_HIGH, self_fmt, mask};
      return code;
   endfunction : make_code

   // self-check mask: causes at 6..2, reserved 1..0 zero
   function automatic logic [`FCR_MASK_W-1:0] make_self_mask(input logic [4:0] causes);
      logic [`FCR_MASK_W-1:0] mask;
      mask = {causes, 2'h0} & `FCR_SELF_MASK;
      return mask;
   endfunction : make_self_mask

   // other mask: reserved ones at 6..5, causes at 4..2, reserved zeros at 1..0
   function automatic logic [`FCR_MASK_W-1:0] make_other_mask(
      input logic misaligned,
      input logic runtime,
      input logic busconf
   );
      logic [`FCR_MASK_W-1:0] mask;
      mask = `FCR_OTHER_ONES;
      mask[`FCR_BIT_ALIGN] = misaligned;
      mask[`FCR_BIT_RUNTIME] = runtime;
      mask[`FCR_BIT_BUSCONF] = busconf;
      return mask;
   endfunction : make_other_mask

   // cause decode
   assign self_err = |self_check_fail_in;
   assign other_err = image_misaligned_in | runtime_error_in | bus_confidence_fail_in;
   assign any_err = self_err | other_err;
   assign mask_self = make_self_mask(self_check_fail_in);
   assign mask_other = make_other_mask(image_misaligned_in, runtime_error_in, bus_confidence_fail_in);
   assign code_self = make_code(1'h1, mask_self);
   assign code_other = make_code(1'h0, mask_other);

   // ready pin shift chain
   generate
      for (genvar g = 0; g < `FCR_SYNC_DEPTH; g++) begin : g_rdy_sync
         if (g == 0) begin : g_first
            assign rdy_sync_d[g] = ready_n_in;
         end else begin : g_next
            assign rdy_sync_d[g] = rdy_sync_q[g-1];
         end
      end
   endgenerate

   // a pin change counts once the second and third stage agree
   always_comb begin
      rdy_d = rdy_q;
      if (rdy_sync_q[`FCR_SYNC_DEPTH-2] == rdy_sync_q[`FCR_SYNC_DEPTH-1]) begin
         rdy_d = ~rdy_sync_q[`FCR_SYNC_DEPTH-1];
      end
   end

   // synchroniser registers only
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdy_sync_q <= {`FCR_SYNC_DEPTH{`FCR_RDY_N_IDLE}};
         rdy_q <= `FCR_RDY_RST;
      end else begin
         rdy_sync_q <= rdy_sync_d;
         rdy_q <= rdy_d;
      end
   end

   // next state of the access sequencer
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         fcr_pkg::FCR_RUN: begin
            // armed in every run phase, not only after self-check
            if (any_err) begin
               state_d = fcr_pkg::FCR_ADDR;
            end
         end
         fcr_pkg::FCR_ADDR: begin
            state_d = fcr_pkg::FCR_WAIT;
         end
         fcr_pkg::FCR_WAIT: begin
            if (access_done(state_q, rdy_q)) begin
               state_d = fcr_pkg::FCR_HALT;
            end
         end
         fcr_pkg::FCR_HALT: begin
            state_d = fcr_pkg::FCR_HALT;
         end
         default: begin
            state_d = fcr_pkg::FCR_HALT;
         end
      endcase
   end

   // state register only
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= fcr_pkg::FCR_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // fail code, indicator, halt and completion
   always_comb begin
      addr_d = addr_q;
      fail_n_d = fail_n_q;
      halt_d = halt_q;
      done_d = done_q;
      if (in_run(state_q)) begin
         if (self_err) begin
            // self-check causes win over the others
            addr_d = code_self;
            fail_n_d = 1'h0;
            halt_d = 1'h1;
         end else if (other_err) begin
            addr_d = code_other;
            fail_n_d = 1'h0;
            halt_d = 1'h1;
         end
      end
      if (access_done(state_q, rdy_q)) begin
         done_d = 1'h1;
      end
   end

   // status registers only
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         addr_q <= `FCR_ADDR_RST;
         fail_n_q <= `FCR_FAIL_N_RST;
         halt_q <= `FCR_HALT_RST;
         done_q <= `FCR_DONE_RST;
      end else begin
         addr_q <= addr_d;
         fail_n_q <= fail_n_d;
         halt_q <= halt_d;
         done_q <= done_d;
      end
   end

   // strobe in the first access clock, last-transfer low through the wait
   assign address_strobe_n_out = ~in_addr_cycle(state_q);
   assign blast_n_out = ~in_access(state_q);
   assign write_not_read_out = `FCR_WNR_READ;
   assign fail_n_out = fail_n_q;
   assign halt_out = halt_q;
   assign addr_out = addr_q;
   assign done_out = done_q;
endmodule : fcr_reporter

//--- test/fcr_chk.sv
`timescale 1ns/1ps
module fcr_chk (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic [4:0] self_check_fail_in,
   input wire logic image_misaligned_in,
   input wire logic runtime_error_in,
   input wire logic bus_confidence_fail_in,
   input wire logic fail_n_out,
   input wire logic halt_out,
   input wire logic [31:0] addr_out,
   input wire logic address_strobe_n_out,
   input wire logic write_not_read_out
);
default clocking @(posedge mclk_in); endclocking
default disable iff (!nrst_in);
wire err=|{self_check_fail_in,image_misaligned_in,runtime_error_in,bus_confidence_fail_in};
a_fail_on_err: assert property (fail_n_out && err |=> !fail_n_out && halt_out) else $error("no fail");
a_fail_stays: assert property (!fail_n_out |=> !fail_n_out && $stable(addr_out)) else $error("moved");
a_idle_high: assert property (fail_n_out && !err |=> fail_n_out) else $error("early");
a_one_strobe: assert property ($fell(address_strobe_n_out) |=> address_strobe_n_out[*8]) else $error("strobe");
a_code_form: assert property (!fail_n_out |-> addr_out[31:8]==24'hFFFFFF && addr_out[1:0]==2'h0) else $error("form");
a_other_ones: assert property (!fail_n_out && !addr_out[7] |-> addr_out[6:5]==2'h3) else $error("ones");
a_self_flag: assert property (fail_n_out && err |=> addr_out[7]==|$past(self_check_fail_in)) else $error("flag");
a_strobe_now: assert property ($fell(fail_n_out) |-> !address_strobe_n_out) else $error("late");
a_read_only: assert property (!address_strobe_n_out |-> !write_not_read_out) else $error("write");
endmodule : fcr_chk
bind fcr_reporter fcr_chk fcr_chk_i(.mclk_in(mclk_in),.nrst_in(nrst_in),.self_check_fail_in(self_check_fail_in),
.image_misaligned_in(image_misaligned_in),.runtime_error_in(runtime_error_in),
.bus_confidence_fail_in(bus_confidence_fail_in),.fail_n_out(fail_n_out),.halt_out(halt_out),.addr_out(addr_out),
.address_strobe_n_out(address_strobe_n_out),.write_not_read_out(write_not_read_out));

//--- test/fcr_mem.sv
`timescale 1ns/1ps
module fcr_mem #(parameter int DLY=2)(input wire logic mclk_in,address_strobe_n_out,blast_n_out,
input wire logic [31:0] addr_out,output logic ready_n_in=1'h1,output logic [7:0] n_access=8'h00,
output logic [31:0] seen_code=32'h00000000);
int c=0;
always @(posedge mclk_in) begin
   c <= !address_strobe_n_out ? DLY : (c>0 ? c-1 : 0);
   ready_n_in <= !(c==0 && !blast_n_out && address_strobe_n_out);
   if (!address_strobe_n_out) begin
      n_access <= n_access+8'h01;
      // receiver drops reserved bits: 1..0 always, 6..5 in the other format
      seen_code <= addr_out & (addr_out[7] ? 32'hFFFFFFFC : 32'hFFFFFF9C);
   end
end
endmodule : fcr_mem

//--- test/fcr_reporter_tb.sv
`timescale 1ns/1ps
module fcr_reporter_tb;
logic mclk_in=0,nrst_in=0,ra,rb,rc;
logic [4:0] sc;
wire fail_n_out,halt_out,address_strobe_n_out,write_not_read_out,blast_n_out,done_out,ready_n_in;
wire [31:0] addr_out,seen_code;
wire [7:0] n_access;
int errors=0,n_compared=0,runs=0;
always #2.5 mclk_in=~mclk_in;
fcr_reporter fcr_reporter_i(.mclk_in,.nrst_in,.self_check_fail_in(sc),.image_misaligned_in(ra),.runtime_error_in(rb),
.bus_confidence_fail_in(rc),.ready_n_in,.fail_n_out,.halt_out,.addr_out,.address_strobe_n_out,.write_not_read_out,
.blast_n_out,.done_out);
fcr_mem fcr_mem_i(.mclk_in,.address_strobe_n_out,.blast_n_out,.addr_out,.ready_n_in,.n_access,.seen_code);
task chk(logic [34:0] g,e);
   n_compared++;
   if (g!==e) begin
      errors++;
      $display("CHECK FAILED %0t %h %h",$time,g,e);
   end
endtask : chk
task wrap_up;
   $display("errors %0d compared %0d",errors,n_compared);
   if (errors==0 && n_compared>0) $display("Finished cleanly");
   else $display("Finished with errors");
   $finish;
endtask : wrap_up
task run(logic [7:0] i,logic [31:0] e,int idle);
   nrst_in=0;
   {sc,ra,rb,rc}=8'h00;
   repeat(16) @(negedge mclk_in);
   nrst_in=1;
   repeat(3) @(negedge mclk_in);
   chk({fail_n_out,halt_out,done_out,address_strobe_n_out,blast_n_out},35'h13);
   chk(addr_out,35'h0);
   repeat(idle) @(negedge mclk_in);
   chk(fail_n_out,35'h1);
   {sc,ra,rb,rc}=i;
   @(negedge mclk_in);
   {sc,ra,rb,rc}=~i;
   chk(addr_out,e);
   chk({fail_n_out,halt_out,address_strobe_n_out,blast_n_out,write_not_read_out},35'h08);
   @(negedge mclk_in);
   chk(address_strobe_n_out,35'h1);
   repeat(20) @(negedge mclk_in);
   chk({fail_n_out,halt_out,done_out,blast_n_out,write_not_read_out},35'h0E);
   chk(addr_out,e);
   runs++;
   chk(n_access,runs);
   chk(seen_code,e&(e[7]?32'hFFFFFFFC:32'hFFFFFF9C));
endtask : run
task test_self_causes;
   for (int k=0;k<5;k++) run(8'h08<<k,32'hFFFFFF80|(32'h4<<k),0);
endtask : test_self_causes
task test_other_causes;
   for (int k=0;k<3;k++) run(8'h01<<k,32'hFFFFFF60|(32'h4<<k),0);
endtask : test_other_causes
task test_priority;
   run(8'h0F,32'hFFFFFF84,0);
   run(8'h07,32'hFFFFFF7C,0);
endtask : test_priority
task test_late_error;
   run(8'h02,32'hFFFFFF68,400);
endtask : test_late_error
initial begin
   test_self_causes();
   test_other_causes();
   test_priority();
   test_late_error();
   wrap_up();
end
initial begin
   #10us;
   errors++;
   wrap_up();
end
endmodule : fcr_reporter_tb
